// ==== src/npc_controller.sv ====
/*
  Bank controller for two NAND flash banks and one 16-bit PC card bank.
  Assumes requests from a system-bus front end on the same clock and
  external pins that the wrapper resolves from the data output enable.
*/
`timescale 1ns/1ps
module npc_controller
  import npc_pkg::*;
(
  input  wire logic                                  CLK,                 // system clock, 25 MHz
  input  wire logic                                  RST,                 // synchronous reset
  input  wire npc_pkg::npc_bank_ctl_t [NUM_BANKS-1:0] BANK_CTL,           // per-bank enable and width
  input  wire npc_pkg::npc_timing_t   [NUM_BANKS-1:0] COMMON_TIMING,      // common space timing
  input  wire npc_pkg::npc_timing_t   [NUM_BANKS-1:0] ATTRIBUTE_TIMING,   // attribute space timing
  input  wire npc_pkg::npc_timing_t                  IO_TIMING,           // card io space timing
  input  wire logic                                  REQ_VALID,           // request offered
  output logic                                       REQ_READY,           // request taken when both high
  input  wire npc_pkg::npc_req_t                     REQ,                 // request fields
  output logic                                       RSP_VALID,           // one-cycle answer pulse
  output npc_pkg::npc_rsp_t                          RSP,                 // answer fields
  output logic                                       BUSY,                // transaction in progress
  output logic [1:0]                                 NAND_CHIP_SELECT_N,  // nand bank chip selects
  output logic                                       READ_STROBE_N,       // read strobe
  output logic                                       WRITE_STROBE_N,      // write strobe
  output logic                                       IO_READ_STROBE_N,    // card io read strobe
  output logic                                       IO_WRITE_STROBE_N,   // card io write strobe
  output logic                                       SPACE_SELECT_N,      // high common, low attr/io
  output logic [1:0]                                 CARD_BYTE_SELECT_N,  // card byte selects
  output logic [ADDR_W-1:0]                          MEM_ADDR,            // address lines
  output logic [DATA_W-1:0]                          MEM_DATA_OUT,        // data bus output
  output logic                                       MEM_DATA_OE,         // high while driving data bus
  input  wire logic [DATA_W-1:0]                     MEM_DATA_IN,         // data bus input
  input  wire logic [1:0]                            NAND_READY_BUSY_IN,  // high ready, low busy
  input  wire logic                                  CARD_STALL_IN,       // high stretches the strobe
  input  wire logic                                  CARD_INTERRUPT_IN,   // card interrupt pin
  input  wire logic                                  CARD_DETECT_IN,      // high when card present
  input  wire logic                                  IO_WIDTH16_IN,       // card io 16-bit pin
  output logic [1:0]                                 NAND_READY,          // filtered ready per bank
  output logic                                       CARD_PRESENT,        // filtered card detect
  output logic                                       CARD_IRQ,            // filtered card interrupt
  output logic                                       IO_WIDTH16           // filtered io width pin
);
  import npc_pkg::*;

  // beats minus one for a transfer size on a device width
  function automatic logic [1:0] last_beat(input logic [1:0] size, input logic w16);
    if (w16) begin
      last_beat = (size == SIZE_32) ? 2'h1 : 2'h0;
    end else begin
      last_beat = (size == SIZE_32) ? 2'h3 : ((size == SIZE_16) ? 2'h1 : 2'h0);
    end
  endfunction : last_beat

  // ---- pin synchronisers: three stages, change counts when 2nd and 3rd agree
  logic [NUM_PINS-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NUM_PINS-1:0] s1_d, s2_d, s3_d, pin_d;
  logic [NUM_PINS-1:0] pins_raw;

  assign pins_raw = {IO_WIDTH16_IN, CARD_DETECT_IN, CARD_INTERRUPT_IN, CARD_STALL_IN, NAND_READY_BUSY_IN};

  always_comb begin
    s1_d  = pins_raw;
    s2_d  = s1_q;
    s3_d  = s2_q;
    pin_d = (pin_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_q  <= PIN_RESET;
      s2_q  <= PIN_RESET;
      s3_q  <= PIN_RESET;
      pin_q <= PIN_RESET;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      pin_q <= pin_d;
    end
  end

  assign NAND_READY   = pin_q[PIN_RDY1:PIN_RDY0];
  assign CARD_PRESENT = pin_q[PIN_DETECT];
  assign CARD_IRQ     = pin_q[PIN_IRQ];
  assign IO_WIDTH16   = pin_q[PIN_IOS16];

  // ---- access sequencer
  npc_state_t         state_q, state_d;
  npc_req_t           req_q, req_d;
  npc_timing_t        tset_q, tset_d;
  logic [1:0]         beat_q, beat_d;
  logic [1:0]         last_q, last_d;
  logic               w16_q, w16_d;
  logic               prewait_q, prewait_d;
  logic [1:0]         addr_seen_q, addr_seen_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               rsp_valid_q, rsp_valid_d;
  logic               rsp_err_q, rsp_err_d;
  logic [ADDR_W-1:0]  addr_q, addr_d;
  logic [DATA_W-1:0]  dout_q, dout_d;
  logic               ph_load, fl_load;
  logic [TIMER_W-1:0] ph_value;
  logic               ph_done, fl_done;

  npc_phase_timer #(.WIDTH(TIMER_W)) u_phase (
    .clk   (CLK),
    .rst   (RST),
    .load  (ph_load),
    .value (ph_value),
    .done  (ph_done)
  );

  npc_phase_timer #(.WIDTH(TIMER_W)) u_float (
    .clk   (CLK),
    .rst   (RST),
    .load  (fl_load),
    .value ({1'b0, tset_d.bus_float}),
    .done  (fl_done)
  );

  logic              is_card, is_nand_q, stall, nand_rdy, refuse, w16_in, use_attr;
  logic [ADDR_W-1:0] beat_addr;
  logic [DATA_W-1:0] beat_wdata;
  logic [DATA_W-1:0] rd_half;

  assign is_card   = (req_q.bank == BANK_CARD);
  assign is_nand_q = !is_card;
  assign stall     = is_card && pin_q[PIN_STALL];
  assign nand_rdy  = pin_q[PIN_RDY0 + int'(req_q.bank[0])];

  always_comb begin
    state_d     = state_q;
    req_d       = req_q;
    tset_d      = tset_q;
    beat_d      = beat_q;
    last_d      = last_q;
    w16_d       = w16_q;
    prewait_d   = prewait_q;
    addr_seen_d = addr_seen_q;
    rdata_d     = rdata_q;
    rsp_valid_d = 1'b0;
    rsp_err_d   = rsp_err_q;
    ph_load     = 1'b0;
    fl_load     = 1'b0;
    ph_value    = {1'b0, tset_q.setup};
    w16_in      = (REQ.bank == BANK_CARD) || BANK_CTL[REQ.bank].width16;
    refuse      = (REQ.bank == 2'h3) || !BANK_CTL[REQ.bank].enable || (REQ.size == 2'h3) ||
                  ((REQ.bank == BANK_CARD) && !pin_q[PIN_DETECT]) ||
                  (w16_in && REQ.write && (REQ.size == SIZE_8));
    use_attr    = (REQ.bank != BANK_CARD) && REQ.write && REQ.addr[CLE_BIT] &&
                  addr_seen_q[REQ.bank[0]];
    rd_half     = (!w16_q || (req_q.size != SIZE_8) || !req_q.addr[0]) ? MEM_DATA_IN :
                  {8'h00, MEM_DATA_IN[15:8]};
    unique case (state_q)
      ST_IDLE: begin
        if (REQ_VALID) begin
          if (refuse) begin
            rsp_valid_d = 1'b1;
            rsp_err_d   = 1'b1;
          end else begin
            req_d     = REQ;
            w16_d     = w16_in;
            beat_d    = 2'h0;
            last_d    = last_beat(REQ.size, w16_in);
            rdata_d   = RDATA_RESET;
            rsp_err_d = 1'b0;
            prewait_d = use_attr || ((REQ.bank != BANK_CARD) && (REQ.space == SPACE_ATTR));
            if ((REQ.bank == BANK_CARD) && (REQ.space == SPACE_IO)) begin
              tset_d = IO_TIMING;
            end else if ((REQ.space == SPACE_ATTR) || use_attr) begin
              tset_d = ATTRIBUTE_TIMING[REQ.bank];
            end else begin
              tset_d = COMMON_TIMING[REQ.bank];
            end
            ph_load  = 1'b1;
            ph_value = {1'b0, tset_d.setup};
            fl_load  = 1'b1;
            state_d  = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // a nand read does not strobe until the memory is ready
        if (ph_done && (is_card || req_q.write || nand_rdy)) begin
          ph_load  = 1'b1;
          ph_value = {1'b0, tset_q.strobe};
          state_d  = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (ph_done && !stall) begin
          if (!req_q.write) begin
            if (w16_q) begin
              rdata_d[16*beat_q +: 16] = rd_half;
            end else begin
              rdata_d[8*beat_q +: 8] = MEM_DATA_IN[7:0];
            end
          end
          ph_load  = 1'b1;
          ph_value = {1'b0, ((tset_q.hold < HOLD_MIN) ? HOLD_MIN : tset_q.hold) - HOLD_MIN};
          state_d  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (ph_done) begin
          if (is_nand_q && req_q.write) begin
            if (req_q.addr[ALE_BIT]) begin
              addr_seen_d[req_q.bank[0]] = 1'b1;
            end else if (req_q.addr[CLE_BIT]) begin
              addr_seen_d[req_q.bank[0]] = 1'b0;
            end
          end
          if (beat_q != last_q) begin
            beat_d   = beat_q + 2'h1;
            ph_load  = 1'b1;
            ph_value = {1'b0, tset_q.setup};
            fl_load  = 1'b1;
            state_d  = ST_SETUP;
          end else if (is_nand_q && prewait_q) begin
            state_d = ST_RDYWAIT;
          end else begin
            rsp_valid_d = 1'b1;
            state_d     = ST_IDLE;
          end
        end
      end
      ST_RDYWAIT: begin
        if (nand_rdy) begin
          rsp_valid_d = 1'b1;
          state_d     = ST_IDLE;
        end
      end
    endcase
    // taken from next-state values so the first beat carries the new request
    beat_addr   = req_d.addr + (w16_d ? ADDR_W'({beat_d, 1'b0}) : ADDR_W'(beat_d));
    beat_wdata  = w16_d ? req_d.wdata[16*beat_d +: 16] : {8'h00, req_d.wdata[8*beat_d +: 8]};
    addr_d = addr_q;
    dout_d = dout_q;
    if (state_d == ST_SETUP) begin
      addr_d = beat_addr;
      dout_d = beat_wdata;
    end
    if (state_d == ST_IDLE) begin
      addr_d = '0;
      dout_d = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q     <= ST_IDLE;
      req_q       <= '0;
      tset_q      <= '0;
      beat_q      <= 2'h0;
      last_q      <= 2'h0;
      w16_q       <= 1'b0;
      prewait_q   <= 1'b0;
      addr_seen_q <= 2'h0;
      rdata_q     <= RDATA_RESET;
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      addr_q      <= '0;
      dout_q      <= '0;
    end else begin
      state_q     <= state_d;
      req_q       <= req_d;
      tset_q      <= tset_d;
      beat_q      <= beat_d;
      last_q      <= last_d;
      w16_q       <= w16_d;
      prewait_q   <= prewait_d;
      addr_seen_q <= addr_seen_d;
      rdata_q     <= rdata_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_err_q   <= rsp_err_d;
      addr_q      <= addr_d;
      dout_q      <= dout_d;
    end
  end

  // ---- pin decode from registered state
  logic active, strobing, io_acc, card_act;

  assign active   = (state_q != ST_IDLE);
  assign strobing = (state_q == ST_STROBE);
  assign card_act = active && is_card;
  assign io_acc   = card_act && (req_q.space == SPACE_IO);

  assign REQ_READY          = (state_q == ST_IDLE);
  assign RSP_VALID          = rsp_valid_q;
  assign RSP                = '{error: rsp_err_q, rdata: rdata_q};
  assign BUSY               = active;
  assign NAND_CHIP_SELECT_N = ~({2{active && is_nand_q}} & {req_q.bank[0], ~req_q.bank[0]});
  assign READ_STROBE_N      = !(strobing && !req_q.write && !io_acc);
  assign WRITE_STROBE_N     = !(strobing && req_q.write && !io_acc);
  assign IO_READ_STROBE_N   = !(strobing && !req_q.write && io_acc);
  assign IO_WRITE_STROBE_N  = !(strobing && req_q.write && io_acc);
  assign SPACE_SELECT_N     = !card_act || (req_q.space == SPACE_COMMON);
  assign CARD_BYTE_SELECT_N = !card_act ? 2'b11 : ((req_q.size == SIZE_8) ? 2'b10 : 2'b00);
  assign MEM_ADDR           = addr_q;
  assign MEM_DATA_OUT       = dout_q;
  assign MEM_DATA_OE        = active && (state_q != ST_RDYWAIT) && req_q.write && fl_done;
endmodule : npc_controller

// ==== src/npc_phase_timer.sv ====
/*
  Down counter that times one access phase.
  Assumes the caller loads it on entry to a phase and watches done.
*/
`timescale 1ns/1ps
module npc_phase_timer #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,    // system clock
  input  wire logic             rst,    // synchronous reset
  input  wire logic             load,   // start a new count
  input  wire logic [WIDTH-1:0] value,  // cycles minus one
  output logic                  done    // count has reached zero
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);
endmodule : npc_phase_timer

// ==== src/npc_pkg.sv ====
/*
  Shared constants and types of the NAND flash / PC card bank controller.
  Assumes a single 25 MHz system clock and a synchronous active-high reset.
*/
package npc_pkg;

  localparam int ADDR_W      = 18;  // external address lines
  localparam int DATA_W      = 16;  // external data lines
  localparam int ALE_BIT     = 17;  // address latch on this address line
  localparam int CLE_BIT     = 16;  // command latch on this address line
  localparam int CARD_ADDR_W = 11;  // card address on lines 10..0
  localparam int NUM_BANKS   = 3;
  localparam int NUM_PINS    = 6;   // synchronised pin inputs
  localparam int TIMER_W     = 9;

  localparam logic [1:0] SIZE_8       = 2'h0;
  localparam logic [1:0] SIZE_16      = 2'h1;
  localparam logic [1:0] SIZE_32      = 2'h2;
  localparam logic [1:0] SPACE_COMMON = 2'h0;
  localparam logic [1:0] SPACE_ATTR   = 2'h1;
  localparam logic [1:0] SPACE_IO     = 2'h2;
  localparam logic [1:0] BANK_NAND_A  = 2'h0;
  localparam logic [1:0] BANK_NAND_B  = 2'h1;
  localparam logic [1:0] BANK_CARD    = 2'h2;

  // pin positions inside the synchroniser vector
  localparam int PIN_RDY0   = 0;
  localparam int PIN_RDY1   = 1;
  localparam int PIN_STALL  = 2;
  localparam int PIN_IRQ    = 3;
  localparam int PIN_DETECT = 4;
  localparam int PIN_IOS16  = 5;

  localparam logic [NUM_PINS-1:0] PIN_RESET   = 6'h00;
  localparam logic [7:0]          HOLD_MIN    = 8'h01;
  localparam logic [31:0]         RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] bus_float;  // 0..255 cycles data bus float after write start
    logic [7:0] hold;       // 1..255 cycles address/data hold
    logic [7:0] strobe;     // value+1 = 1..256 cycles command strobe
    logic [7:0] setup;      // value+1 = 1..256 cycles address setup
  } npc_timing_t;

  typedef struct packed {
    logic enable;
    logic width16;          // nand banks only; the card bank is always 16-bit
  } npc_bank_ctl_t;

  typedef struct packed {
    logic [1:0]        bank;
    logic [1:0]        space;
    logic              write;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } npc_req_t;

  typedef struct packed {
    logic        error;
    logic [31:0] rdata;
  } npc_rsp_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SETUP   = 5'b00010,
    ST_STROBE  = 5'b00100,
    ST_HOLD    = 5'b01000,
    ST_RDYWAIT = 5'b10000
  } npc_state_t;

endpackage : npc_pkg

// ==== verification/npc_flash_model.sv ====
/*
  Behavioural nand chip and card data source.
  Assumes data depends only on the address and bank 0 goes busy after a 30h command.
*/
`timescale 1ns/1ps
module npc_flash_model
  import npc_pkg::*;
(
  input  wire logic              clk,    // system clock
  input  wire logic [1:0]        sel_n,  // any select low
  input  wire logic              rd_n,   // any read strobe
  input  wire logic              wr_n,   // any write strobe
  input  wire logic [ADDR_W-1:0] a,      // address lines
  input  wire logic [DATA_W-1:0] d_out,  // controller data
  output logic      [DATA_W-1:0] d_in,   // data to controller
  output logic      [1:0]        rb      // ready per bank
);
  logic [DATA_W-1:0] last = 16'h0000;
  logic [31:0]       hist_q = 32'h0;
  logic              cle_q = 1'b0;
  logic              ale_q = 1'b0;
  logic              wr_p = 1'b1;
  int                busy_n = 0;

  // address pattern lets reads run on across pages
  assign d_in = (!rd_n && sel_n != 2'b11) ? {a[7:0] ^ 8'h3c, a[7:0] ^ 8'h5a} : ~last;
  assign rb   = (busy_n > 0) ? 2'b10 : 2'b11;

  always @(posedge clk) begin
    wr_p <= wr_n;
    if (!rd_n) begin
      last <= d_in;
    end
    if (wr_n && !wr_p) begin  // take data on strobe rise
      hist_q <= {d_out[7:0], hist_q[31:8]};
      cle_q  <= a[CLE_BIT];
      ale_q  <= a[ALE_BIT];
      if (a[CLE_BIT] && d_out[7:0] == 8'h30) begin
        busy_n <= 20;
      end
    end else if (busy_n > 0) begin
      busy_n <= busy_n - 1;
    end
  end
endmodule : npc_flash_model

// ==== verification/npc_monitor.sv ====
/*
  Concurrent checks on the bank controller ports.
  Assumes the bench keeps one strobe width in all timing sets and a float count
  no longer than the shortest setup phase.
*/
`timescale 1ns/1ps
module npc_monitor
  import npc_pkg::*;
(
  input wire logic                              CLK,                 // clock
  input wire logic                              RST,                 // reset
  input wire logic                              REQ_VALID,           // request offered
  input wire logic                              REQ_READY,           // request taken
  input wire npc_pkg::npc_req_t                 REQ,                 // request fields
  input wire npc_pkg::npc_timing_t [NUM_BANKS-1:0] COMMON_TIMING,    // common timing
  input wire logic                              BUSY,                // in progress
  input wire logic [1:0]                        NAND_CHIP_SELECT_N,  // nand selects
  input wire logic                              READ_STROBE_N,       // read strobe
  input wire logic                              WRITE_STROBE_N,      // write strobe
  input wire logic                              IO_READ_STROBE_N,    // io read
  input wire logic                              IO_WRITE_STROBE_N,   // io write
  input wire logic                              SPACE_SELECT_N,      // space select
  input wire logic [1:0]                        CARD_BYTE_SELECT_N,  // card selects
  input wire logic [ADDR_W-1:0]                 MEM_ADDR,            // address lines
  input wire logic [DATA_W-1:0]                 MEM_DATA_OUT,        // data out
  input wire logic                              MEM_DATA_OE,         // data enable
  input wire logic [1:0]                        NAND_READY           // filtered ready
);
  logic       strb_lo;
  logic [8:0] lo_q, lo_d;
  npc_req_t   cap_q, cap_d;

  assign strb_lo = !(READ_STROBE_N && WRITE_STROBE_N && IO_READ_STROBE_N && IO_WRITE_STROBE_N);

  always_comb begin
    lo_d  = strb_lo ? lo_q + 9'h1 : 9'h0;
    cap_d = (REQ_VALID && REQ_READY) ? REQ : cap_q;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      lo_q  <= 9'h0;
      cap_q <= '0;
    end else begin
      lo_q  <= lo_d;
      cap_q <= cap_d;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  sequence strobe_start;
    $rose(strb_lo);
  endsequence
  sequence strobe_end;
    $fell(strb_lo);
  endsequence

  a_idle_quiet: assert property (!BUSY |-> &{NAND_CHIP_SELECT_N, READ_STROBE_N, WRITE_STROBE_N,
    IO_READ_STROBE_N, IO_WRITE_STROBE_N, CARD_BYTE_SELECT_N} && !MEM_DATA_OE) else $error("idle pins active");
  a_reset_ready: assert property ($past(RST) |-> REQ_READY && !BUSY)
    else $error("not idle after reset");
  a_setup_span: assert property (strobe_start |-> $stable(MEM_ADDR) && $past(BUSY))
    else $error("address not set up before strobe");
  a_strobe_min: assert property (strobe_end |-> lo_q >= {1'b0, COMMON_TIMING[0].strobe} + 9'h1)
    else $error("strobe too short");
  a_hold_after: assert property (strobe_end |-> $stable(MEM_ADDR) && (!cap_q.write || $stable(MEM_DATA_OUT))
    && (NAND_CHIP_SELECT_N != 2'b11 || CARD_BYTE_SELECT_N != 2'b11)) else $error("hold phase cut short");
  a_float_start: assert property ($rose(BUSY) |-> !MEM_DATA_OE)
    else $error("data driven at access start");
  a_write_drive: assert property (!WRITE_STROBE_N || !IO_WRITE_STROBE_N |-> MEM_DATA_OE)
    else $error("write strobe with floating bus");
  a_io_only: assert property (!IO_READ_STROBE_N || !IO_WRITE_STROBE_N |-> READ_STROBE_N && WRITE_STROBE_N
    && !SPACE_SELECT_N && cap_q.space == SPACE_IO) else $error("io strobe misuse");
  a_space_sel: assert property (CARD_BYTE_SELECT_N != 2'b11 |-> SPACE_SELECT_N == (cap_q.space == SPACE_COMMON))
    else $error("space select wrong");
  a_nand_latch: assert property (NAND_CHIP_SELECT_N != 2'b11 |-> MEM_ADDR[ALE_BIT:CLE_BIT] == cap_q.addr[ALE_BIT:CLE_BIT])
    else $error("latch lines wrong");
  a_card_addr: assert property (strb_lo && CARD_BYTE_SELECT_N != 2'b11
    |-> MEM_ADDR[CARD_ADDR_W-1:2] == cap_q.addr[CARD_ADDR_W-1:2]) else $error("card address wrong");
  a_ready_wait: assert property (!NAND_CHIP_SELECT_N[0] && !NAND_READY[0] |=> !NAND_CHIP_SELECT_N[0])
    else $error("select dropped while busy");
endmodule : npc_monitor

// ==== verification/test_nand_pccard_controller.sv ====
/*
  Self-checking bench for the nand / card bank controller.
  Assumes the flash model on the pins and the monitor bound below.
*/
`timescale 1ns/1ps
module test_nand_pccard_controller;
  import npc_pkg::*;
  logic                    clk, rst, req_valid, req_ready, rsp_valid, busy, rd_n, wr_n, iord_n, iowr_n;
  logic                    sel_n, oe, stall, irq_in, det, ios16, present, irq, ios;
  logic [1:0]              cs_n, cbs_n, rb, rdy;
  logic [ADDR_W-1:0]       addr;
  logic [DATA_W-1:0]       dout, din;
  npc_bank_ctl_t [2:0]     bctl;
  npc_timing_t   [2:0]     ct, at;
  npc_timing_t             iot;
  npc_req_t                req;
  npc_rsp_t                rsp;
  int                      mismatches, checks, cyc, lat, su, nf, nio;

  npc_controller uut (.CLK(clk), .RST(rst), .BANK_CTL(bctl), .COMMON_TIMING(ct), .ATTRIBUTE_TIMING(at),
    .IO_TIMING(iot), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp),
    .BUSY(busy), .NAND_CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .IO_READ_STROBE_N(iord_n), .IO_WRITE_STROBE_N(iowr_n), .SPACE_SELECT_N(sel_n), .CARD_BYTE_SELECT_N(cbs_n),
    .MEM_ADDR(addr), .MEM_DATA_OUT(dout), .MEM_DATA_OE(oe), .MEM_DATA_IN(din), .NAND_READY_BUSY_IN(rb),
    .CARD_STALL_IN(stall), .CARD_INTERRUPT_IN(irq_in), .CARD_DETECT_IN(det), .IO_WIDTH16_IN(ios16),
    .NAND_READY(rdy), .CARD_PRESENT(present), .CARD_IRQ(irq), .IO_WIDTH16(ios));

  npc_flash_model fm (.clk(clk), .sel_n(cs_n & cbs_n), .rd_n(rd_n & iord_n), .wr_n(wr_n & iowr_n), .a(addr),
    .d_out(dout), .d_in(din), .rb(rb));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask : chk

  // one request from a falling edge; counts cycles, strobe starts and io strobe starts
  task automatic xfer(input logic [1:0] b, sp, input logic w, input logic [1:0] sz, input logic [17:0] a,
                      input logic [31:0] wd);
    logic p, s;
    req = '{b, sp, w, sz, a, wd};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    lat = 1; su = 0; nf = 0; nio = 0; p = 1'b1;
    while (rsp_valid !== 1'b1 && lat < 400) begin
      s = rd_n & wr_n & iord_n & iowr_n;
      if (!s && p) begin
        nf++;
        if (su == 0) su = lat;
        if (!(iord_n & iowr_n)) nio++;
      end
      p = s;
      @(negedge clk);
      lat++;
    end
    if (rsp_valid !== 1'b1) begin
      chk("rsp timeout", 32'h1, 32'h0);
    end
  endtask : xfer

  task automatic t_pins;
    chk("idle pins", 32'h7e, {25'h0, cs_n, rd_n, wr_n, iord_n, iowr_n, oe});
    chk("ready", 32'h3, {30'h0, rdy});
    xfer(BANK_CARD, SPACE_COMMON, 1'b0, SIZE_16, 18'h0, 32'h0);
    chk("absent card", 32'h1, {31'h0, rsp.error} + 32'(nf));
    det = 1'b1;
    irq_in = 1'b1;
    ios16 = 1'b1;
    repeat (8) @(negedge clk);
    chk("present irq", 32'h7, {29'h0, ios, present, irq});
    $display("test pins done");
  endtask : t_pins

  task automatic t_cmd;
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b1, SIZE_8, 18'h10000, 32'h0);
    chk("cmd", 32'h100, {22'h0, fm.ale_q, fm.cle_q, fm.hist_q[31:24]});
    chk("cmd cycles", 32'h38, 32'(su * 16 + lat));
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b1, SIZE_8, 18'h20000, 32'h12);
    chk("addr", 32'h212, {22'h0, fm.ale_q, fm.cle_q, fm.hist_q[31:24]});
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b1, SIZE_8, 18'h10000, 32'h30);
    chk("confirm setup", 32'h5, 32'(su));
    chk("prewait", 32'h1, {31'h0, lat > 28});
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b1, SIZE_8, 18'h10000, 32'h0);
    chk("plain setup", 32'h3, 32'(su));
    $display("test cmd done");
  endtask : t_cmd

  task automatic t_byte;
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b0, SIZE_32, 18'h4, 32'h0);
    chk("rd32", 32'h5d5c5f5e, rsp.rdata);
    chk("rd32 beats", 32'h41d, 32'(nf * 256 + lat));
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b1, SIZE_16, 18'h4, 32'ha1b2);
    chk("wr16", 32'h2000a1b2, {nf[3:0], 12'h0, fm.hist_q[31:16]});
    xfer(BANK_NAND_A, SPACE_COMMON, 1'b0, SIZE_8, 18'h4, 32'h0);
    chk("rd8", 32'h15e, 32'(nf * 256) + rsp.rdata);
    $display("test byte done");
  endtask : t_byte

  task automatic t_half;
    xfer(BANK_NAND_B, SPACE_COMMON, 1'b1, SIZE_8, 18'h4, 32'h0);
    chk("byte write", 32'h1, {31'h0, rsp.error} + 32'(nf));
    xfer(BANK_NAND_B, SPACE_COMMON, 1'b0, SIZE_8, 18'h1, 32'h0);
    chk("odd byte", 32'h3d, rsp.rdata);
    xfer(BANK_NAND_B, SPACE_COMMON, 1'b1, SIZE_32, 18'h4, 32'h1234);
    chk("wr32 beats", 32'h2, 32'(nf) + {31'h0, rsp.error});
    xfer(BANK_NAND_B, SPACE_COMMON, 1'b0, SIZE_32, 18'h4, 32'h0);
    chk("rd32", 32'h3a5c385e, rsp.rdata);
    chk("rd32 beats", 32'h2, 32'(nf));
    $display("test half done");
  endtask : t_half

  task automatic t_card;
    xfer(BANK_CARD, SPACE_COMMON, 1'b0, SIZE_16, 18'h7fe, 32'h0);
    chk("common rd", 32'h3c2a4, 32'(su) * 32'h10000 + rsp.rdata);
    xfer(BANK_CARD, SPACE_ATTR, 1'b1, SIZE_16, 18'h4, 32'h55);
    chk("attr wr", 32'h510, 32'(su * 256 + nf * 16 + nio));
    xfer(BANK_CARD, SPACE_IO, 1'b0, SIZE_16, 18'h2, 32'h0);
    chk("io rd", 32'h4113e58, 32'(su * 16 + nio) * 32'h100000 + 32'(nf) * 32'h10000 + rsp.rdata);
    xfer(BANK_CARD, SPACE_IO, 1'b1, SIZE_32, 18'h0, 32'h0);
    chk("io wr32", 32'h2, 32'(nio));
    stall = 1'b1;
    fork
      xfer(BANK_CARD, SPACE_COMMON, 1'b0, SIZE_16, 18'h0, 32'h0);
      begin
        repeat (12) @(negedge clk);
        stall = 1'b0;
      end
    join
    chk("stall rd", 32'h133c5a, 32'(lat) * 32'h10000 + rsp.rdata);
    $display("test card done");
  endtask : t_card

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    mismatches = 0; checks = 0; cyc = 0;
    rst = 1'b1; req_valid = 1'b0; req = '0; stall = 1'b0; irq_in = 1'b0; det = 1'b0; ios16 = 1'b0;
    for (int i = 0; i < 3; i++) begin
      bctl[i] = '{1'b1, i == 1};
      ct[i]   = '{8'h01, 8'h02, 8'h02, 8'h01};
      at[i]   = '{8'h01, 8'h08, 8'h02, 8'h03};
    end
    iot = '{8'h01, 8'h03, 8'h02, 8'h02};
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_pins();
    t_cmd();
    t_byte();
    t_half();
    t_card();
    summarize();
  end
endmodule : test_nand_pccard_controller

bind npc_controller npc_monitor u_mon (.CLK, .RST, .REQ_VALID, .REQ_READY, .REQ, .COMMON_TIMING, .BUSY,
  .NAND_CHIP_SELECT_N, .READ_STROBE_N, .WRITE_STROBE_N, .IO_READ_STROBE_N, .IO_WRITE_STROBE_N, .SPACE_SELECT_N,
  .CARD_BYTE_SELECT_N, .MEM_ADDR, .MEM_DATA_OUT, .MEM_DATA_OE, .NAND_READY);
